// file: src/iobmc_top.sv
// I/O bus master control registers: APB slave, PCI header, config cycles.
//
// Local design decision: the APB register port.
`default_nettype none

// --------------------------------------------------------------------------
// --------------------------------------------------------------------------

module iobmc_top #(
  parameter logic [15:0] FUNCTION_CODE = 16'h5a5a, // Arbitrary value.
  parameter logic [15:0] VENDOR_CODE = 16'ha5a5, // Arbitrary value.
  parameter logic [3:0] REV_MAJOR = 4'h1, // Arbitrary value.
  parameter logic [3:0] REV_MINOR = 4'h2 // Arbitrary value.
) (
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // I/O bus side: clock, straps, configuration cycle handshake.
  input wire logic I_BUS_CLK,
  input wire logic I_AGP_MODE,
  input wire logic I_BUS_64,
  output iobmc_pkg::iobmc_cfg_req_t O_CFG,
  input wire logic I_CFG_ACK,
  input wire logic [31:0] I_CFG_RDATA,
  output logic O_BUS_RESET,
  // Bridge events and target decode from same-clock logic.
  input wire iobmc_pkg::iobmc_evt_t I_EVT,
  input wire logic I_MEM_HIT,
  input wire logic I_VGA_RANGE,
  // Controls toward the bridge's bus logic.
  output logic O_MEM_CLAIM,
  output logic O_SERR,
  output logic O_PERR_RESPOND,
  output logic O_IO_FAIL_HARD,
  output logic O_IO_FAIL_ONES,
  output logic O_LOG_CLEAR,
  output logic O_LINE_128,
  output logic [7:0] O_LATENCY_TIMER,
  output logic [2:0] O_XFERS_AFTER_LT
);

  // ------------------------------------------------------------------------
  // State record: every flip-flop of the block lives here.
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic bclk_meta; // Bus clock synchroniser, first stage.
    logic bclk_sync; // Bus clock synchroniser, second stage.
    logic bclk_prev; // Previous synchronised bus clock level.
    logic ack_meta; // Acknowledge synchroniser, first stage.
    logic ack_sync; // Acknowledge synchroniser, second stage.
    logic agp_meta; // Strap synchroniser, first stage.
    logic agp_sync; // Strap synchroniser, second stage.
    logic [1:0] strap_age; // Edges since reset, saturating at three.
    logic agp_mode; // Captured strap.
    logic [15:0] command; // PCI command field.
    logic [5:0] sticky; // Sticky status bits, DPE down to MDPE.
    logic [7:0] line_size; // Cache line size field.
    logic [7:0] lat_timer; // Latency timer field.
    logic fail_response_select; // Hard-fail when set, all ones if clear.
    logic clear_enable; // Error log clearing allowed.
    logic log_clear_request; // Last clear attempt succeeded.
    logic vga_forward; // VGA range left to the peer bus.
    logic bus_reset_request; // Downstream bus held in reset.
    logic [31:0] cfg_addr; // Configuration address register.
    iobmc_pkg::iobmc_cfg_state_t cfg_state; // Configuration sequencer.
    logic [2:0] precharge; // Bus clock edges left before request.
    iobmc_pkg::iobmc_cfg_req_t cfg; // Request driven to the bus.
    logic [31:0] cfg_rdata; // Data captured from a config read.
    logic [31:0] rdata; // APB read data.
    logic slverr; // Unmapped-address answer.
    logic serr; // System error output.
    logic perr_respond; // Parity response output.
    logic fail_hard; // Hard-fail pulse.
    logic fail_ones; // All-ones pulse.
    logic log_clear; // Log erase pulse.
  } iobmc_state_t;

  iobmc_state_t s; // Current state.
  iobmc_state_t next_s; // Next state.

  // ------------------------------------------------------------------------
  // Decode helpers.
  // ------------------------------------------------------------------------
  logic setup; // APB setup phase.
  logic access; // APB access phase.
  logic hit_cfg_data; // Access targets the configuration data word.
  logic hit_cfg_addr; // Access targets the configuration address word.
  logic mapped; // Address lands on a known word.
  logic ready; // Access phase completes this cycle.
  logic bclk_rise; // Rising edge seen on the bus clock.
  logic [31:0] read_word; // Word a read would return now.
  logic [15:0] status; // Full status field.
  logic [31:0] ctrl_word; // Control word as read.
  logic [4:0] dev_num; // Device number of the config address.
  logic [31:0] bus_addr; // Address phase value built from cfg_addr.

  assign setup = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE;
  assign hit_cfg_data = (I_PADDR == iobmc_pkg::OFS_CFG_DATA);
  assign hit_cfg_addr = (I_PADDR == iobmc_pkg::OFS_CFG_ADDR);
  assign bclk_rise = s.bclk_sync & ~s.bclk_prev;
  assign dev_num = s.cfg_addr[15:11];

  // Status: fixed capability bits plus the six sticky event bits.
  assign status = iobmc_pkg::STAT_FIXED | {s.sticky[5:1], 2'b00,
    s.sticky[0], 8'h00};

  // Control word; bit 5 always reads as zero, and the bus reset request reads back in bit 0.
  assign ctrl_word = {26'h0, 1'b0, s.vga_forward,
    s.log_clear_request, s.clear_enable, s.fail_response_select,
    s.bus_reset_request};

  // Type 0 cycles put a one-hot IDSEL on AD[31:16]; type 1 passes the
  // bus number on. Devices above 15 get no select line at all.
  always_comb
  begin
    bus_addr = 32'h0;
    if (s.cfg_addr[23:16] == 8'h00)
    begin
      if (!dev_num[4])
      begin
        bus_addr[5'd16 + dev_num] = 1'b1;
      end
      bus_addr[10:2] = s.cfg_addr[10:2];
    end
    else
    begin
      bus_addr = {8'h00, s.cfg_addr[23:2], 2'b01};
    end
  end

  // ------------------------------------------------------------------------
  // Read multiplexer, sampled in the setup phase.
  // ------------------------------------------------------------------------
  always_comb
  begin
    mapped = 1'b1;
    read_word = 32'h0;
    case (I_PADDR)
      iobmc_pkg::OFS_ID_LO: read_word = {FUNCTION_CODE, VENDOR_CODE};
      iobmc_pkg::OFS_ID_HI: read_word = {status, s.command};
      iobmc_pkg::OFS_CLASS_LO:
        read_word = {iobmc_pkg::CLASS_HOST_BRIDGE, REV_MAJOR, REV_MINOR};
      iobmc_pkg::OFS_CLASS_HI: read_word = {16'h0, s.lat_timer, s.line_size};
      iobmc_pkg::OFS_CAP_PTR: read_word = {24'h0, s.agp_mode ?
        iobmc_pkg::CAP_AGP : iobmc_pkg::CAP_PCIX};
      iobmc_pkg::OFS_CAP_PTR_HI: read_word = 32'h0;
      iobmc_pkg::OFS_CFG_ADDR: read_word = s.cfg_addr;
      iobmc_pkg::OFS_CFG_DATA: read_word = s.cfg_rdata;
      iobmc_pkg::OFS_CTRL: read_word = ctrl_word;
      iobmc_pkg::OFS_CTRL_HI: read_word = 32'h0;
      default: mapped = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------------
  // Access completion. Config data and config address wait on the
  // sequencer, which is what lets software wait for a posted write to end.
  // ------------------------------------------------------------------------
  always_comb
  begin
    ready = 1'b1;
    if (hit_cfg_data && !I_PWRITE)
    begin
      ready = (s.cfg_state == iobmc_pkg::CS_DONE);
    end
    else if (hit_cfg_data || hit_cfg_addr)
    begin
      ready = (s.cfg_state == iobmc_pkg::CS_IDLE) & ~s.ack_sync;
    end
  end

  // ------------------------------------------------------------------------
  // Next-state logic for the whole block.
  // ------------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // Synchronisers: the first stages feed only the second stages.
    next_s.bclk_meta = I_BUS_CLK;
    next_s.bclk_sync = s.bclk_meta;
    next_s.bclk_prev = s.bclk_sync;
    next_s.ack_meta = I_CFG_ACK;
    next_s.ack_sync = s.ack_meta;
    next_s.agp_meta = I_AGP_MODE;
    next_s.agp_sync = s.agp_meta;
    // Strap is caught once, on the third edge after reset, when the
    // synchroniser holds the pin rather than its own reset value.
    if (s.strap_age != 2'h3)
    begin
      next_s.strap_age = s.strap_age + 2'h1;
    end
    if (s.strap_age == 2'h2)
    begin
      next_s.agp_mode = s.agp_sync;
    end
    next_s.fail_hard = 1'b0;
    next_s.fail_ones = 1'b0;
    next_s.log_clear = 1'b0;
    next_s.slverr = 1'b0;

    // Read data is latched in the setup phase so it comes from a register.
    if (setup)
    begin
      next_s.rdata = mapped ? read_word : 32'h0;
      next_s.slverr = ~mapped;
    end
    else if (access && !ready)
    begin
      next_s.slverr = s.slverr;
    end

    // Register writes take effect on the completing access edge.
    if (access && ready && I_PWRITE)
    begin
      case (I_PADDR)
        iobmc_pkg::OFS_ID_HI:
        begin
          // Bus master bit is stored and read back only; no logic acts on it.
          next_s.command = I_PWDATA[15:0];
          next_s.sticky = s.sticky & ~{I_PWDATA[31:27],
            I_PWDATA[24]};
        end
        iobmc_pkg::OFS_CLASS_HI:
        begin
          next_s.line_size = I_PWDATA[7:0];
          next_s.lat_timer = I_PWDATA[15:8];
        end
        iobmc_pkg::OFS_CFG_ADDR: next_s.cfg_addr = I_PWDATA;
        iobmc_pkg::OFS_CTRL:
        begin
          next_s.fail_response_select = I_PWDATA[iobmc_pkg::CTRL_FAIL_BIT];
          next_s.clear_enable = I_PWDATA[iobmc_pkg::CTRL_CE_BIT];
          next_s.vga_forward = I_PWDATA[iobmc_pkg::CTRL_VGA_BIT];
          next_s.bus_reset_request = I_PWDATA[iobmc_pkg::CTRL_RST_BIT];
          // Clear only if the enable was already set before this write.
          if (I_PWDATA[iobmc_pkg::CTRL_CLR_BIT])
          begin
            next_s.log_clear_request = s.clear_enable;
            next_s.log_clear = s.clear_enable;
          end
        end
        default:
        begin
          next_s.cfg_addr = next_s.cfg_addr;
        end
      endcase
    end

    // A freshly logged error locks out clearing, winning over a write.
    if (I_EVT.error_logged)
    begin
      next_s.clear_enable = 1'b0;
    end

    // Event bits set after the clear so that a coincident event survives.
    if (I_EVT.parity_detected)
    begin
      next_s.sticky[5] = 1'b1;
    end
    if (I_EVT.serr_request && s.command[iobmc_pkg::CMD_SERR_EN_BIT])
    begin
      next_s.sticky[4] = 1'b1;
    end
    if (I_EVT.master_abort)
    begin
      next_s.sticky[3] = 1'b1;
    end
    if (I_EVT.target_abort_rcvd)
    begin
      next_s.sticky[2] = 1'b1;
    end
    if (I_EVT.target_abort_sig)
    begin
      next_s.sticky[1] = 1'b1;
    end
    // Master data parity is a parity response, suppressed when disabled.
    if (I_EVT.master_data_parity &&
        s.command[iobmc_pkg::CMD_PERR_RESP_BIT])
    begin
      next_s.sticky[0] = 1'b1;
    end

    // System error and parity responses are gated by the command field.
    next_s.serr = I_EVT.serr_request &
      s.command[iobmc_pkg::CMD_SERR_EN_BIT];
    next_s.perr_respond = (I_EVT.parity_detected |
      I_EVT.master_data_parity) & s.command[iobmc_pkg::CMD_PERR_RESP_BIT];

    // Failed processor I/O answer style.
    if (I_EVT.io_error)
    begin
      next_s.fail_hard = s.fail_response_select;
      next_s.fail_ones = ~s.fail_response_select;
    end

    // Configuration cycle sequencer. Only one cycle exists at a time;
    // further data accesses stall on the APB until it ends.
    case (s.cfg_state)
      iobmc_pkg::CS_IDLE:
      begin
        if (access && hit_cfg_data && I_PWRITE && ready)
        begin
          next_s.cfg_state = iobmc_pkg::CS_PRECHARGE;
        end
        else if (access && hit_cfg_data && !I_PWRITE && !s.ack_sync)
        begin
          next_s.cfg_state = iobmc_pkg::CS_PRECHARGE;
        end
        next_s.cfg.write = I_PWRITE;
        next_s.cfg.wdata = I_PWDATA;
        next_s.cfg.addr = bus_addr;
        next_s.cfg.type1 = (s.cfg_addr[23:16] != 8'h00);
        next_s.precharge = iobmc_pkg::PRECHARGE_BUS_CLKS;
      end
      iobmc_pkg::CS_PRECHARGE:
      begin
        // The select line settles for a few bus clocks before the cycle.
        if (bclk_rise)
        begin
          next_s.precharge = s.precharge - 3'h1;
          if (s.precharge == 3'h1)
          begin
            next_s.cfg.req = 1'b1;
            next_s.cfg_state = iobmc_pkg::CS_ACTIVE;
          end
        end
      end
      iobmc_pkg::CS_ACTIVE:
      begin
        if (s.ack_sync)
        begin
          next_s.cfg.req = 1'b0;
          if (s.cfg.write)
          begin
            next_s.cfg_state = iobmc_pkg::CS_IDLE;
          end
          else
          begin
            next_s.cfg_rdata = I_CFG_RDATA;
            next_s.rdata = I_CFG_RDATA;
            next_s.cfg_state = iobmc_pkg::CS_DONE;
          end
        end
      end
      iobmc_pkg::CS_DONE:
      begin
        if (access && hit_cfg_data && !I_PWRITE)
        begin
          next_s.cfg_state = iobmc_pkg::CS_IDLE;
        end
      end
      default:
      begin
        next_s.cfg_state = iobmc_pkg::CS_IDLE;
        next_s.cfg.req = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------------
  // State register; reset loads constants only.
  // ------------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      s <= '0;
      s.command <= iobmc_pkg::RST_COMMAND;
      s.line_size <= iobmc_pkg::RST_LINE;
      s.lat_timer <= iobmc_pkg::RST_LAT;
      s.cfg_addr <= iobmc_pkg::RST_CFG_ADDR;
      s.cfg_state <= iobmc_pkg::CS_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs.
  // ------------------------------------------------------------------------
  assign O_PRDATA = s.rdata;
  assign O_PREADY = ready;
  assign O_PSLVERR = s.slverr & ready;
  assign O_CFG = s.cfg;
  assign O_BUS_RESET = s.bus_reset_request;
  // VGA range is left to the peer bus when forwarding is on.
  assign O_MEM_CLAIM = I_MEM_HIT & s.command[iobmc_pkg::CMD_MEM_BIT] &
    ~(s.vga_forward & I_VGA_RANGE);
  assign O_SERR = s.serr;
  assign O_PERR_RESPOND = s.perr_respond;
  assign O_IO_FAIL_HARD = s.fail_hard;
  assign O_IO_FAIL_ONES = s.fail_ones;
  assign O_LOG_CLEAR = s.log_clear;
  assign O_LINE_128 = (s.line_size == iobmc_pkg::LINE_128);
  assign O_LATENCY_TIMER = s.lat_timer;
  assign O_XFERS_AFTER_LT = I_BUS_64 ? iobmc_pkg::XFERS_AFTER_LT_64 :
    iobmc_pkg::XFERS_AFTER_LT_32;

endmodule

`default_nettype wire

// file: src/iobmc_pkg.sv
// Constants and carrier types of the I/O bus master control register block.
`default_nettype none

package iobmc_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses (each 64-bit register is two 32-bit words).
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_ID_LO = 12'h000; // Vendor and function codes.
  localparam logic [11:0] OFS_ID_HI = 12'h004; // Command and status.
  localparam logic [11:0] OFS_CLASS_LO = 12'h008; // Revision and class.
  localparam logic [11:0] OFS_CLASS_HI = 12'h00c; // Line size, timer.
  localparam logic [11:0] OFS_CAP_PTR = 12'h030; // Capability pointer.
  localparam logic [11:0] OFS_CAP_PTR_HI = 12'h034; // Upper word, zero.
  localparam logic [11:0] OFS_CFG_ADDR = 12'h040; // Configuration address.
  localparam logic [11:0] OFS_CFG_DATA = 12'h048; // Configuration data.
  localparam logic [11:0] OFS_CTRL = 12'h108; // Reset, error, VGA control.
  localparam logic [11:0] OFS_CTRL_HI = 12'h10c; // Upper word, zero.

  // ----------------------------------------------------------------------
  // Command field (lower half of the ID_HI word).
  // ----------------------------------------------------------------------
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_PERR_RESP_BIT = 6;
  localparam int CMD_SERR_EN_BIT = 8;

  // ----------------------------------------------------------------------
  // Status field: fixed part and sticky bits (upper half of ID_HI word).
  // ----------------------------------------------------------------------
  localparam logic [15:0] STAT_FIXED = 16'h02b0; // Caps, 66MHz, FB2B, medium.
  localparam int STAT_MDPE_BIT = 8;
  localparam int STAT_STA_BIT = 11;
  localparam int STAT_RTA_BIT = 12;
  localparam int STAT_RMA_BIT = 13;
  localparam int STAT_SSE_BIT = 14;
  localparam int STAT_DPE_BIT = 15;

  // ----------------------------------------------------------------------
  // Class, line size and capability constants.
  // ----------------------------------------------------------------------
  localparam logic [23:0] CLASS_HOST_BRIDGE = 24'h060000;
  localparam logic [7:0] LINE_128 = 8'h20;
  localparam logic [7:0] CAP_AGP = 8'h60;
  localparam logic [7:0] CAP_PCIX = 8'ha0;
  localparam logic [2:0] XFERS_AFTER_LT_32 = 3'h4;
  localparam logic [2:0] XFERS_AFTER_LT_64 = 3'h2;

  // ----------------------------------------------------------------------
  // Control word bit positions.
  // ----------------------------------------------------------------------
  localparam int CTRL_DONE_BIT = 0;
  localparam int CTRL_FAIL_BIT = 1;
  localparam int CTRL_CE_BIT = 2;
  localparam int CTRL_CLR_BIT = 3;
  localparam int CTRL_VGA_BIT = 4;
  localparam int CTRL_RST_BIT = 5;

  // ----------------------------------------------------------------------
  // Configuration cycle timing and reset values.
  // ----------------------------------------------------------------------
  localparam logic [2:0] PRECHARGE_BUS_CLKS = 3'h4;
  localparam logic [15:0] RST_COMMAND = 16'h0000;
  localparam logic [7:0] RST_LINE = 8'h00;
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [31:0] RST_CFG_ADDR = 32'h00000000;

  // Sequencer of one configuration cycle, one-hot.
  typedef enum logic [3:0] {
    CS_IDLE = 4'b0001,
    CS_PRECHARGE = 4'b0010,
    CS_ACTIVE = 4'b0100,
    CS_DONE = 4'b1000
  } iobmc_cfg_state_t;

  // Error events from the bridge's bus logic, one-cycle pulses.
  typedef struct packed {
    logic parity_detected; // Address or data parity error seen.
    logic serr_request; // Bus logic wants to signal a system error.
    logic master_abort; // Own transaction master-aborted.
    logic target_abort_rcvd; // Own transaction target-aborted.
    logic target_abort_sig; // Bridge ended a transaction with abort.
    logic master_data_parity; // Own transaction saw data parity error.
    logic error_logged; // A new error entered the logs.
    logic io_error; // A processor I/O read or port write failed.
  } iobmc_evt_t;

  // Configuration cycle request toward the I/O bus.
  typedef struct packed {
    logic req; // Level, held until the acknowledge arrives.
    logic write; // 1 write, 0 read.
    logic type1; // 1 type 1 cycle, 0 type 0.
    logic [31:0] addr; // Address phase AD value, IDSEL included.
    logic [31:0] wdata; // Write data.
  } iobmc_cfg_req_t;

endpackage

`default_nettype wire

// file: tb/iobmc_asserts.sv
// Checker of the I/O bus master control block, bound to its top.
`default_nettype none
module iobmc_asserts (
  // Watched ports.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic I_BUS_64,
  input wire iobmc_pkg::iobmc_cfg_req_t O_CFG,
  input wire logic I_CFG_ACK,
  input wire logic O_BUS_RESET,
  input wire iobmc_pkg::iobmc_evt_t I_EVT,
  input wire logic I_MEM_HIT,
  input wire logic O_MEM_CLAIM,
  input wire logic O_SERR,
  input wire logic O_PERR_RESPOND,
  input wire logic O_IO_FAIL_HARD,
  input wire logic O_IO_FAIL_ONES,
  input wire logic [2:0] O_XFERS_AFTER_LT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // A completed write to the control word.
  wire logic ctrl_wr = I_PSEL & I_PENABLE & I_PWRITE
    & (I_PADDR == iobmc_pkg::OFS_CTRL);
  // The card answered a pending cycle.
  sequence s_ack;
    $rose(I_CFG_ACK) ##0 O_CFG.req;
  endsequence
  AST_CFG_HOLD: assert property (O_CFG.req && !I_CFG_ACK |=>
    O_CFG.req && $stable(O_CFG.addr)) else $error("cfg request dropped");
  AST_CFG_DONE: assert property (s_ack |-> ##[1:4] !O_CFG.req)
    else $error("cfg request outlives ack");
  AST_IDSEL: assert property (O_CFG.req && !O_CFG.type1 |->
    $onehot0(O_CFG.addr[31:16])) else $error("bad device select");
  AST_BUS_RESET: assert property ($changed(O_BUS_RESET) |->
    $past(ctrl_wr)) else $error("bus reset moved without write");
  AST_SERR: assert property (O_SERR |-> $past(I_EVT.serr_request))
    else $error("system error without cause");
  AST_PERR: assert property (O_PERR_RESPOND |->
    $past(I_EVT.parity_detected | I_EVT.master_data_parity))
    else $error("parity response without parity error");
  AST_IO_FAIL: assert property (O_IO_FAIL_HARD || O_IO_FAIL_ONES |->
    $past(I_EVT.io_error) && !(O_IO_FAIL_HARD && O_IO_FAIL_ONES))
    else $error("bad failed access response");
  AST_MEM: assert property (O_MEM_CLAIM |-> I_MEM_HIT)
    else $error("claim without hit");
  AST_XFERS: assert property (O_XFERS_AFTER_LT == (I_BUS_64 ? 3'h2 :
    3'h4)) else $error("wrong transfers after timer");
endmodule
bind iobmc_top iobmc_asserts u_asrt (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_BUS_64(I_BUS_64), .O_CFG(O_CFG),
  .I_CFG_ACK(I_CFG_ACK), .O_BUS_RESET(O_BUS_RESET), .I_EVT(I_EVT),
  .I_MEM_HIT(I_MEM_HIT), .O_MEM_CLAIM(O_MEM_CLAIM), .O_SERR(O_SERR),
  .O_PERR_RESPOND(O_PERR_RESPOND), .O_IO_FAIL_HARD(O_IO_FAIL_HARD),
  .O_IO_FAIL_ONES(O_IO_FAIL_ONES), .O_XFERS_AFTER_LT(O_XFERS_AFTER_LT));
`default_nettype wire

// file: tb/iobmc_bus_model.sv
// Model of the card answering configuration cycles on the I/O bus.
`default_nettype none
module iobmc_bus_model (
  // Request and pacing.
  input wire iobmc_pkg::iobmc_cfg_req_t i_cfg,
  input wire logic i_slow,
  // Bus clock and answer.
  output logic o_bus_clk,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [64]; // Card registers by word.
  initial
  begin
    o_bus_clk = 1'b0;
    o_ack = 1'b0;
    o_rdata = 32'h0;
    foreach (regs[i]) regs[i] = 32'h0;
  end
  // The slot clock runs free.
  always #80 o_bus_clk = ~o_bus_clk;
  // Four-phase answer, prompt or stalled.
  always
  begin
    @(posedge i_cfg.req);
    repeat (i_slow ? 6 : 1) @(posedge o_bus_clk);
    if (i_cfg.write)
      regs[i_cfg.addr[7:2]] = i_cfg.wdata;
    o_rdata = regs[i_cfg.addr[7:2]];
    o_ack = 1'b1;
    @(negedge i_cfg.req);
    o_ack = 1'b0;
    o_rdata = ~o_rdata; // Stale data must never look valid.
  end
endmodule
`default_nettype wire

// file: tb/iobmc_top_tb.sv
// Self-checking bench of the I/O bus master control registers.
`default_nettype none
module iobmc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] FC = 16'h1357; // Arbitrary value.
  localparam logic [15:0] VC = 16'h2468; // Arbitrary value.
  localparam logic [11:0] CT = iobmc_pkg::OFS_CTRL;
  localparam logic [11:0] IH = iobmc_pkg::OFS_ID_HI;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err, rdy, slverr;
  logic bclk, agp = 0, b64 = 0, ack, hit = 0, vga = 0, slow = 0, brst;
  logic claim, serr, perr, hard, ones, l128, lclr;
  logic [2:0] xf;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, q, cdat;
  logic [7:0] lat;
  logic [3:0] snap;
  logic [7:0] ls [3] = '{8'h20, 8'h10, 8'h21};
  iobmc_pkg::iobmc_cfg_req_t cfg;
  iobmc_pkg::iobmc_evt_t evt = '0;
  int n_errors = 0, tests_run = 0, n_clr = 0;
  always #5 clk = ~clk;
  // Count clear pulses so a one-cycle output cannot slip past a check.
  always @(posedge clk)
    if (lclr === 1'b1)
      n_clr <= n_clr + 1;
  iobmc_top #(.FUNCTION_CODE(FC), .VENDOR_CODE(VC), .REV_MAJOR(4'h3),
    .REV_MINOR(4'h1)) DUT (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
    .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(slverr), .I_BUS_CLK(bclk),
    .I_AGP_MODE(agp), .I_BUS_64(b64), .O_CFG(cfg), .I_CFG_ACK(ack),
    .I_CFG_RDATA(cdat), .O_BUS_RESET(brst), .I_EVT(evt), .I_MEM_HIT(hit),
    .I_VGA_RANGE(vga), .O_MEM_CLAIM(claim), .O_SERR(serr),
    .O_PERR_RESPOND(perr), .O_IO_FAIL_HARD(hard), .O_IO_FAIL_ONES(ones),
    .O_LOG_CLEAR(lclr), .O_LINE_128(l128), .O_LATENCY_TIMER(lat),
    .O_XFERS_AFTER_LT(xf));
  iobmc_bus_model u_bus (.i_cfg(cfg), .i_slow(slow), .o_bus_clk(bclk),
    .o_ack(ack), .o_rdata(cdat));
  // One APB transfer; an idle cycle follows so strobes never double up.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = prd;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Compare and count.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One-cycle event pulse; snapshot the registered reactions.
  task automatic ev(input iobmc_pkg::iobmc_evt_t e);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    @(negedge clk);
    snap = {serr, perr, hard, ones};
    @(posedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the few microseconds the tests need.
  initial
  begin
    #300us;
    n_errors++;
    end_sim;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    apb(0, iobmc_pkg::OFS_ID_LO, 0);
    chk(q, {FC, VC});
    apb(0, IH, 0);
    chk(q[31:16], iobmc_pkg::STAT_FIXED);
    apb(0, iobmc_pkg::OFS_CLASS_LO, 0);
    chk(q, 32'h06000031);
    apb(0, iobmc_pkg::OFS_CAP_PTR, 0);
    chk(q, 32'h000000a0);
    chk(xf, 4);
    apb(0, 12'h200, 0);
    chk(err, 1);
    apb(1, CT, 32'h20);
    apb(0, CT, 0);
    chk({brst, q}, 33'h100000001);
    apb(1, CT, 0);
    apb(0, CT, 0);
    chk({brst, q}, 0);
    apb(1, CT, 32'h4);
    ev(8'h02);
    apb(0, CT, 0);
    chk(q, 0);
    apb(1, CT, 32'h8);
    apb(0, CT, 0);
    chk(q, 0);
    apb(1, CT, 32'h4);
    apb(1, CT, 32'hc);
    apb(0, CT, 0);
    chk(q, 32'hc);
    chk(n_clr, 1);
    $display("control test done");
    for (int h = 0; h < 2; h++)
    begin
      apb(1, CT, 32'(h * 2));
      ev(8'h01);
      chk(snap[1:0], h ? 2 : 1);
    end
    apb(1, IH, 32'h146);
    ev(8'hfc);
    chk(snap[3:2], 3);
    apb(0, IH, 0);
    chk(q[31:16], 16'hfbb0);
    apb(1, IH, 32'hf9000002);
    ev(8'hc0);
    chk(snap[3:2], 0);
    apb(0, IH, 0);
    chk(q[31:16], 16'h82b0);
    hit <= 1'b1;
    vga <= 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      apb(1, CT, 32'(f * 16));
      chk(claim, 32'(1 - f));
    end
    vga <= 1'b0;
    apb(1, IH, 0);
    chk(claim, 0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, iobmc_pkg::OFS_CLASS_HI, {16'h0, 8'h40, ls[i]});
      chk({lat, l128}, {8'h40, i == 0});
    end
    $display("status test done");
    apb(1, iobmc_pkg::OFS_CFG_ADDR, 32'h1808);
    apb(1, iobmc_pkg::OFS_CFG_DATA, 32'h12345678);
    chk({cfg.type1, cfg.addr[31:16]}, 17'h00008);
    apb(0, iobmc_pkg::OFS_CFG_ADDR, 0);
    chk(q, 32'h1808);
    slow <= 1'b1;
    b64 <= 1'b1;
    apb(1, iobmc_pkg::OFS_CFG_ADDR, 32'h11808);
    apb(0, iobmc_pkg::OFS_CFG_DATA, 0);
    chk(q, 32'h12345678);
    chk(cfg.addr, 32'h11809);
    chk(xf, 2);
    rst_n <= 1'b0;
    agp <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    apb(0, iobmc_pkg::OFS_CAP_PTR, 0);
    chk(q, 32'h60);
    $display("config test done");
    end_sim;
  end
endmodule
`default_nettype wire
